/* rtl/wdrc_defines.vh */
// Constants for the watchdog and reset-control block
`ifndef WDRC_DEFINES_VH
`define WDRC_DEFINES_VH

// ****************************************************************
// Register map
// ****************************************************************
// Offsets are word indices; the byte address is four times the index
`define WDRC_MODE_OFS 8'h0f
`define WDRC_CTRL_OFS 8'h10
`define WDRC_STAT_OFS 8'h14
`define WDRC_MODE_RST 8'h0d
`define WDRC_PER_LSB 0
`define WDRC_HALT_BIT 2
`define WDRC_STOP_BIT 3
`define WDRC_SRC_BIT 4
`define WDRC_CTRL_KICK 0
`define WDRC_CTRL_IDLE 1
`define WDRC_CTRL_STOP 2
`define WDRC_CTRL_SREC 3

// ****************************************************************
// Timing
// ****************************************************************
`define WDRC_CLK_MHZ 100
`define WDRC_XT0 256
`define WDRC_XT1 512
`define WDRC_XT2 1024
`define WDRC_XT3 4096
`define WDRC_RC0_MS 5
`define WDRC_RC1_MS 10
`define WDRC_RC2_MS 20
`define WDRC_RC3_MS 80
`define WDRC_POR_MS 5
`define WDRC_OPEN_CYC 64
`define WDRC_RST_CLKS 18

`endif

/* rtl/wdrc_top.v */
// Watchdog timer, mode register and reset sequencing
//
// Implementation choice: the AXI4-Lite slave port.
`include "wdrc_defines.vh"

module wdrc_top #(
    parameter RC_HZ = 32768,
    parameter MS_CYC = 100000,
    parameter RC_DIV = 1526
) (
    input wire aclk, // Clock
    input wire aresetn, // Sync reset, low active
    input wire clk_en, // Freezes all state when low
    input wire clear_in_one_n, // Timer clear one
    input wire clear_in_two_n, // Timer clear two
    input wire crystal_input_pin, // Crystal clock pin
    input wire power_good, // Supply above power-on level
    input wire low_voltage, // Supply below low_voltage_threshold
    input wire stop_recovery, // Stop-mode wake event
    input wire recovery_delay, // Recovery runs the one-shot
    input wire [31:0] s_axi_awaddr, // AXI write address
    input wire s_axi_awvalid, // AXI
    output reg s_axi_awready, // AXI
    input wire [31:0] s_axi_wdata, // AXI
    input wire [3:0] s_axi_wstrb, // AXI
    input wire s_axi_wvalid, // AXI
    output reg s_axi_wready, // AXI
    output reg [1:0] s_axi_bresp, // AXI
    output reg s_axi_bvalid, // AXI
    input wire s_axi_bready, // AXI
    input wire [31:0] s_axi_araddr, // AXI
    input wire s_axi_arvalid, // AXI
    output reg s_axi_arready, // AXI
    output reg [31:0] s_axi_rdata, // AXI
    output reg [1:0] s_axi_rresp, // AXI
    output reg s_axi_rvalid, // AXI
    input wire s_axi_rready, // AXI
    output reg global_reset_r, // Full chip reset
    output reg partial_reset_r, // Stop-recovery partial reset
    output reg watchdog_fired_r // Pulse on watchdog expiry
);

    // ****************************************************************
    // Synchronisers
    // ****************************************************************
    reg [4:0] sync1_r;
    reg [4:0] sync2_r;
    reg [4:0] prev_r;
    wire clear_in_one_n_s = sync2_r[0];
    wire clear_in_two_n_s = sync2_r[1];
    wire xtal_s = sync2_r[2];
    wire pgood_s = sync2_r[3];
    wire lowv_s = sync2_r[4];

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            prev_r <= 5'h00;
        end else if (clk_en) begin
            sync1_r <= {low_voltage, power_good, crystal_input_pin,
                clear_in_two_n, clear_in_one_n};
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // ****************************************************************
    // Period selection
    // ****************************************************************
    localparam [31:0] POR_CYC = `WDRC_POR_MS * MS_CYC;

    // Crystal periods in crystal edges, RC periods in system cycles
    function [31:0] period_of;
        input [1:0] code;
        input src_xtal;
        begin
            case (code)
                2'd0: period_of = src_xtal ? `WDRC_XT0 : `WDRC_RC0_MS * MS_CYC;
                2'd1: period_of = src_xtal ? `WDRC_XT1 : `WDRC_RC1_MS * MS_CYC;
                2'd2: period_of = src_xtal ? `WDRC_XT2 : `WDRC_RC2_MS * MS_CYC;
                default: period_of = src_xtal ? `WDRC_XT3 : `WDRC_RC3_MS * MS_CYC;
            endcase
        end
    endfunction

    // Registers are whole words, so the two low address bits are ignored
    function [7:0] reg_index;
        input [31:0] byte_addr;
        begin
            reg_index = byte_addr[9:2];
        end
    endfunction

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg [7:0] mode_r;
    reg [3:0] ctrl_r;
    reg [6:0] open_cnt_r;
    reg wd_run_r;
    reg [31:0] wd_cnt_r;
    reg [31:0] por_cnt_r;
    reg por_act_r;
    reg [4:0] rst18_cnt_r;
    reg timers_en_r;
    reg lowv_seen_r;
    reg [31:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg aw_have_r;
    reg w_have_r;

    // ****************************************************************
    // Edges and mode fields
    // ****************************************************************
    wire [1:0] period_code = mode_r[`WDRC_PER_LSB +: 2];
    wire clr_rise = (clear_in_one_n_s & ~prev_r[0]) | (clear_in_two_n_s & ~prev_r[1]);
    wire xtal_rise = xtal_s & ~prev_r[2];
    wire pgood_rise = pgood_s & ~prev_r[3];
    wire lowv_fall = ~lowv_s & prev_r[4];
    wire src_xtal = mode_r[`WDRC_SRC_BIT];
    wire wd_tick = src_xtal ? xtal_rise : 1'b1;
    wire wd_hold = (ctrl_r[`WDRC_CTRL_IDLE] & ~mode_r[`WDRC_HALT_BIT])
        | (ctrl_r[`WDRC_CTRL_STOP] & ~mode_r[`WDRC_STOP_BIT]);
    wire wd_count = wd_run_r & timers_en_r & ~wd_hold & wd_tick;
    wire wd_expire = wd_count & (wd_cnt_r == 32'h0000_0001);
    wire srec_del = stop_recovery & recovery_delay;
    wire por_trig = pgood_rise | wd_expire | srec_del | lowv_fall;
    wire wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
    wire kick = wr_go && reg_index(aw_addr_r) == `WDRC_CTRL_OFS && w_strb_r[0]
        && w_data_r[`WDRC_CTRL_KICK];

    // ****************************************************************
    // Register decode
    // ****************************************************************
    reg [7:0] mode_nxt;
    reg [3:0] ctrl_nxt;
    reg [1:0] bresp_nxt;
    reg [31:0] rdata_nxt;
    reg [1:0] rresp_nxt;

    always @* begin
        mode_nxt = mode_r;
        ctrl_nxt = ctrl_r;
        bresp_nxt = 2'b00;
        case (reg_index(aw_addr_r))
            `WDRC_MODE_OFS: begin
                // Late writes are dropped silently but still answered OKAY
                if (open_cnt_r != 7'd0 && w_strb_r[0])
                    mode_nxt = {3'b000, w_data_r[4:0]};
            end
            `WDRC_CTRL_OFS: begin
                if (w_strb_r[0])
                    ctrl_nxt = {w_data_r[3:1], 1'b0};
            end
            `WDRC_STAT_OFS: bresp_nxt = 2'b00;
            default: bresp_nxt = 2'b10;
        endcase
    end

    // Mode register reads as zero so its setup stays hidden
    always @* begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = 2'b00;
        case (reg_index(s_axi_araddr))
            `WDRC_MODE_OFS: rdata_nxt = 32'h0000_0000;
            `WDRC_CTRL_OFS: rdata_nxt = {28'h000_0000, ctrl_r};
            `WDRC_STAT_OFS: rdata_nxt = {24'h00_0000, 1'b0,
                open_cnt_r != 7'd0, lowv_seen_r, por_act_r,
                timers_en_r, wd_run_r, partial_reset_r, global_reset_r};
            default: rresp_nxt = 2'b10;
        endcase
    end

    // ****************************************************************
    // Watchdog next state
    // ****************************************************************
    reg wd_run_nxt;
    reg [31:0] wd_cnt_nxt;

    // A kick in the expiry cycle reloads the counter, but wd_expire still fires watchdog_fired_r and por_trig
    always @* begin
        wd_run_nxt = wd_run_r;
        wd_cnt_nxt = wd_cnt_r;
        if (kick) begin
            wd_run_nxt = 1'b1;
            wd_cnt_nxt = period_of(period_code, src_xtal);
        end else if (wd_expire) begin
            wd_run_nxt = 1'b0;
            wd_cnt_nxt = 32'h0000_0000;
        end else if (wd_count) begin
            // Crystal source steps on synced pin edges, RC on every cycle
            wd_cnt_nxt = wd_cnt_r - 32'h0000_0001;
        end
    end

    // ****************************************************************
    // One-shot next state
    // ****************************************************************
    reg por_act_nxt;
    reg [31:0] por_cnt_nxt;
    reg [4:0] rst18_cnt_nxt;

    always @* begin
        por_act_nxt = por_act_r;
        por_cnt_nxt = por_cnt_r;
        rst18_cnt_nxt = rst18_cnt_r;
        // Low supply keeps reloading so the full delay runs after it clears
        if (lowv_s || por_trig) begin
            por_act_nxt = 1'b1;
            por_cnt_nxt = POR_CYC;
        end else if (por_act_r && timers_en_r) begin
            if (por_cnt_r <= 32'h0000_0001) begin
                por_act_nxt = 1'b0;
                rst18_cnt_nxt = 5'd`WDRC_RST_CLKS;
            end else begin
                por_cnt_nxt = por_cnt_r - 32'h0000_0001;
            end
        end else if (rst18_cnt_r != 5'h00) begin
            rst18_cnt_nxt = rst18_cnt_r - 5'h01;
        end
    end

    // ****************************************************************
    // Mode write window
    // ****************************************************************
    reg [6:0] open_cnt_nxt;

    // Window restarts only once the reset that opened it has dropped
    always @* begin
        if (global_reset_r || partial_reset_r)
            open_cnt_nxt = 7'd`WDRC_OPEN_CYC;
        else if (open_cnt_r != 7'd0)
            open_cnt_nxt = open_cnt_r - 7'd1;
        else
            open_cnt_nxt = 7'd0;
    end

    // ****************************************************************
    // Write channel
    // ****************************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 32'h0000_0000;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            mode_r <= `WDRC_MODE_RST;
            ctrl_r <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= bresp_nxt;
                mode_r <= mode_nxt;
                ctrl_r <= ctrl_nxt;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (global_reset_r)
                ctrl_r <= 4'h0;
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_nxt;
                s_axi_rresp <= rresp_nxt;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Watchdog, one-shot and reset sequencing
    // ****************************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            wd_run_r <= 1'b0;
            wd_cnt_r <= 32'h0000_0000;
            por_cnt_r <= 32'h0000_0000;
            por_act_r <= 1'b1;
            rst18_cnt_r <= 5'h00;
            timers_en_r <= 1'b0;
            lowv_seen_r <= 1'b0;
            open_cnt_r <= 7'd`WDRC_OPEN_CYC;
            global_reset_r <= 1'b1;
            partial_reset_r <= 1'b0;
            watchdog_fired_r <= 1'b0;
        end else if (clk_en) begin
            watchdog_fired_r <= wd_expire;
            if (clr_rise)
                timers_en_r <= 1'b1;
            if (lowv_s)
                lowv_seen_r <= 1'b1;
            wd_run_r <= wd_run_nxt;
            wd_cnt_r <= wd_cnt_nxt;
            por_act_r <= por_act_nxt;
            por_cnt_r <= por_cnt_nxt;
            rst18_cnt_r <= rst18_cnt_nxt;
            // Low supply stops the watchdog outright
            if (lowv_s)
                wd_run_r <= 1'b0;
            global_reset_r <= lowv_s | por_act_r | por_trig
                | (rst18_cnt_r != 5'h00);
            partial_reset_r <= stop_recovery & ~recovery_delay;
            open_cnt_r <= open_cnt_nxt;
        end
    end

endmodule // wdrc_top

/* verif/wdrc_chk.sv */
// Port-level assertion checker for the watchdog reset block
module wdrc_chk (
    input wire aclk, // Clock
    input wire aresetn, // Reset, low active
    input wire clk_en, // Clock enable
    input wire low_voltage, // Supply low
    input wire stop_recovery, // Wake event
    input wire recovery_delay, // Wake runs one-shot
    input wire s_axi_bvalid, // AXI
    input wire s_axi_bready, // AXI
    input wire s_axi_rvalid, // AXI
    input wire s_axi_rready, // AXI
    input wire [1:0] s_axi_rresp, // AXI
    input wire [31:0] s_axi_rdata, // AXI
    input wire global_reset_r, // Chip reset
    input wire partial_reset_r, // Partial reset
    input wire watchdog_fired_r // Expiry pulse
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ****
    // Checks
    // ****
    // Six cycles covers the two-stage sync of the supply flag
    sequence lv_long;
        (low_voltage && clk_en)[*6];
    endsequence
    chk_lv_hold: assert property (lv_long |-> global_reset_r)
        else $error("chip reset low under low supply");
    chk_lv_release: assert property (lv_long ##1 !low_voltage |-> global_reset_r[*8])
        else $error("chip reset dropped right after supply recovered");
    chk_fire_pulse: assert property (watchdog_fired_r |=> !watchdog_fired_r)
        else $error("expiry pulse longer than one cycle");
    chk_fire_reset: assert property (watchdog_fired_r |-> ##[0:3] global_reset_r)
        else $error("expiry without chip reset");
    chk_wake_part: assert property (clk_en && stop_recovery && !recovery_delay
        |=> partial_reset_r)
        else $error("fast wake without partial reset");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response withdrawn");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read response changed while waiting");
    chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 0)
        else $error("error read returned data");
endmodule // wdrc_chk

bind wdrc_top wdrc_chk u_chk (.aclk, .aresetn, .clk_en, .low_voltage, .stop_recovery,
    .recovery_delay, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rresp, .s_axi_rdata, .global_reset_r, .partial_reset_r, .watchdog_fired_r);

/* verif/wdrc_core.sv */
// Processor core model: register writes, reads and refreshes
module wdrc_core (
    input wire aclk, // Clock
    output logic [31:0] s_axi_awaddr = 32'h0000_0000, // AXI
    output logic s_axi_awvalid = 1'h0, // AXI
    input wire s_axi_awready, // AXI
    output logic [31:0] s_axi_wdata = 32'h0000_0000, // AXI
    output logic s_axi_wvalid = 1'h0, // AXI
    input wire s_axi_wready, // AXI
    input wire s_axi_bvalid, // AXI
    output logic s_axi_bready = 1'h0, // AXI
    output logic [31:0] s_axi_araddr = 32'h0000_0000, // AXI
    output logic s_axi_arvalid = 1'h0, // AXI
    input wire s_axi_arready, // AXI
    input wire [31:0] s_axi_rdata, // AXI
    input wire [1:0] s_axi_rresp, // AXI
    input wire s_axi_rvalid, // AXI
    output logic s_axi_rready = 1'h0, // AXI
    output logic hung = 1'h0 // A bus answer never came
);
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 40);
        s_axi_bready <= 1'h0;
        hung |= (n >= 40);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 40);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        hung |= (n >= 40);
        @(posedge aclk);
    endtask
    task automatic kick;
        wr(32'h0000_0040, 32'h0000_0001);
    endtask
endmodule // wdrc_core

/* verif/watchdog_reset_control_test.sv */
// Self-checking bench for the watchdog reset block
module watchdog_reset_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0, aresetn = 1'h0, clear_in_one_n = 1'h0, clear_in_two_n = 1'h0;
    logic power_good = 1'h0, low_voltage = 1'h0, stop_recovery = 1'h0, recovery_delay = 1'h0;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hung;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
    logic [1:0] s_axi_rresp, rrsp;
    logic global_reset_r, partial_reset_r, watchdog_fired_r;
    logic [1:0] xt = 2'h0;
    logic clk_en = 1'h1;
    int fail_count = 0, checks_done = 0;
    // Crystal runs at a quarter of aclk so the pin sync never misses an edge
    wire crystal_input_pin = xt[1];
    always #5 aclk = ~aclk;
    always @(posedge aclk) xt <= xt + 2'h1;
    wdrc_top #(.MS_CYC(10)) DUT (.aclk, .aresetn, .clk_en, .clear_in_one_n,
        .clear_in_two_n, .crystal_input_pin, .power_good, .low_voltage, .stop_recovery,
        .recovery_delay, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp(), .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .global_reset_r, .partial_reset_r,
        .watchdog_fired_r);
    wdrc_core core (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .hung);
    // ****
    // Helpers
    // ****
    task automatic close_out;
        fail_count += int'(hung);
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge hung) close_out();
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_for(input logic want, input int lo, input int hi);
        int n;
        n = 0;
        while ((want ? watchdog_fired_r : !global_reset_r) !== 1'h1 && n < hi) begin
            @(posedge aclk);
            n++;
        end
        if (n >= hi) begin
            fail_count++;
            close_out();
        end else
            chk(32'(n >= lo), 32'h0000_0001);
    endtask
    // Reset must be seen high before its release is timed
    task automatic wait_low(input int lo);
        chk({31'h0, global_reset_r}, 32'h0000_0001);
        repeat (4) @(posedge aclk);
        wait_for(1'h0, lo, 2000);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_boot;
        clear_in_one_n <= 1'h1;
        clear_in_two_n <= 1'h1;
        power_good <= 1'h1;
        wait_for(1'h0, 60, 2000);
        $display("boot done");
    endtask
    task automatic t_default;
        core.kick();
        repeat (60) @(posedge aclk);
        core.kick();
        clk_en <= 1'h0;
        repeat (200) @(posedge aclk);
        chk({30'h0, global_reset_r, watchdog_fired_r}, 32'h0000_0000);
        clk_en <= 1'h1;
        wait_for(1'h1, 95, 116);
        wait_low(40);
        $display("default period done");
    endtask
    task automatic t_crystal;
        core.wr(32'h0000_003c, 32'h0000_0014);
        core.rd(32'h0000_003c, rdat, rrsp);
        chk(rdat, 32'h0000_0000);
        core.rd(32'h0000_0100, rdat, rrsp);
        chk({30'h0, rrsp}, 32'h0000_0002);
        repeat (70) @(posedge aclk);
        core.wr(32'h0000_003c, 32'h0000_001d);
        core.kick();
        wait_for(1'h1, 1000, 1061);
        wait_low(40);
        $display("crystal period done");
    endtask
    task automatic t_idle;
        core.wr(32'h0000_003c, 32'h0000_0000);
        core.wr(32'h0000_0040, 32'h0000_0003);
        repeat (120) @(posedge aclk);
        chk({30'h0, global_reset_r, watchdog_fired_r}, 32'h0000_0000);
        core.wr(32'h0000_0040, 32'h0000_0000);
        wait_for(1'h1, 38, 71);
        wait_low(40);
        $display("idle halt done");
    endtask
    task automatic t_supply;
        low_voltage <= 1'h1;
        repeat (10) @(posedge aclk);
        chk({31'h0, global_reset_r}, 32'h0000_0001);
        low_voltage <= 1'h0;
        wait_low(40);
        stop_recovery <= 1'h1;
        repeat (3) @(posedge aclk);
        chk({30'h0, partial_reset_r, global_reset_r}, 32'h0000_0002);
        stop_recovery <= 1'h0;
        recovery_delay <= 1'h1;
        @(posedge aclk);
        stop_recovery <= 1'h1;
        @(posedge aclk);
        stop_recovery <= 1'h0;
        @(posedge aclk);
        chk({30'h0, partial_reset_r, global_reset_r}, 32'h0000_0001);
        wait_low(40);
        $display("supply and wake done");
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_boot();
        t_default();
        t_crystal();
        t_idle();
        t_supply();
        close_out();
    end
endmodule // watchdog_reset_control_test
